//--- shared/mbms_regs.svh
`ifndef MBMS_REGS_SVH
`define MBMS_REGS_SVH
// Table and list sizes
`define MBMS_CMD_MAX 7'h64
`define MBMS_TABLE_WORDS 16'h1388
`define MBMS_MAX_WORDS 16'h007d
`define MBMS_MAX_BITS 16'h3e80
// Entry enable modes
`define MBMS_EN_DISABLED 2'h0
`define MBMS_EN_CONTINUOUS 2'h1
`define MBMS_EN_CONDITIONAL 2'h2
// Function codes
`define MBMS_FC_RD_COILS 8'h01
`define MBMS_FC_RD_INPUTS 8'h02
`define MBMS_FC_RD_HOLDING 8'h03
`define MBMS_FC_RD_INPUT_REGS 8'h04
`define MBMS_FC_WR_COIL 8'h05
`define MBMS_FC_WR_REG 8'h06
`define MBMS_FC_WR_COILS 8'h0f
`define MBMS_FC_WR_REGS 8'h10
// Error values
`define MBMS_ERR_NONE 8'h00
`define MBMS_ERR_ENABLE 8'h01
`define MBMS_ERR_FUNC 8'h02
`define MBMS_ERR_COUNT 8'h03
`define MBMS_ERR_RANGE 8'h04
`define MBMS_ERR_TIMEOUT 8'hff
// Handshake switch value
`define MBMS_HANDSHAKE_ON 8'h01
// Timing
`define MBMS_CLK_HZ 32'h02faf080
`define MBMS_TIMEOUT_MS 32'h000003e8
`endif

//--- shared/mbms_pkg.sv
`include "mbms_regs.svh"
package mbms_pkg;
    typedef struct packed {
        logic [1:0] enable;
        logic [7:0] slave;
        logic [7:0] func;
        logic [15:0] db_addr;
        logic [15:0] count;
    } mbms_entry_t;

    typedef struct packed {
        logic [6:0] index;
        mbms_entry_t entry;
    } mbms_req_t;

    typedef enum logic [2:0] {
        PH_IDLE, PH_SELECT, PH_HANDSHAKE, PH_ISSUE, PH_SEND, PH_WAIT, PH_STATUS
    } mbms_phase_t;

    typedef struct packed {
        mbms_phase_t phase;
        logic [6:0] cmd_count;
        logic [6:0] index;
        logic is_event;
        mbms_req_t req;
        logic [15:0] words;
        logic [15:0] word_idx;
        logic [31:0] timer;
        logic [7:0] code;
        logic [99:0][7:0] errs;
        logic [99:0] dirty;
        logic cts_meta;
        logic cts_sync;
        logic rts;
        logic req_valid;
        logic tx_valid;
        logic [15:0] tx_word;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
        logic image_wr;
        logic [15:0] image_addr;
        logic [15:0] image_data;
        logic event_taken;
        logic event_done;
        logic [7:0] event_err;
        logic [15:0] host_rdata;
        logic [7:0] err_rdata;
    } mbms_state_t;
endpackage

//--- logic/mbms_entry_check.sv
`timescale 1ns/1ns
`include "mbms_regs.svh"
module mbms_entry_check (
    // Entry under test
    input wire mbms_pkg::mbms_entry_t i_entry,
    // Verdict and table span
    output logic [7:0] o_error,
    output logic [15:0] o_words
);
    logic is_bits;
    logic is_regs;
    logic is_single;

    // Function class decode
    always_comb begin
        is_bits = (i_entry.func == `MBMS_FC_RD_COILS) || (i_entry.func == `MBMS_FC_RD_INPUTS)
            || (i_entry.func == `MBMS_FC_WR_COILS);
        is_regs = (i_entry.func == `MBMS_FC_RD_HOLDING) || (i_entry.func == `MBMS_FC_RD_INPUT_REGS)
            || (i_entry.func == `MBMS_FC_WR_REGS);
        is_single = (i_entry.func == `MBMS_FC_WR_COIL) || (i_entry.func == `MBMS_FC_WR_REG);
    end

    // Bit counts occupy whole words in the table
    always_comb begin
        if (is_bits) begin
            o_words = 16'((i_entry.count + 16'h000f) >> 4);
        end else if (is_single) begin
            o_words = 16'h0001;
        end else begin
            o_words = i_entry.count;
        end
    end

    // First failing check wins
    always_comb begin
        o_error = `MBMS_ERR_NONE;
        if (i_entry.enable > `MBMS_EN_CONDITIONAL) begin
            o_error = `MBMS_ERR_ENABLE;
        end else if (!(is_bits || is_regs || is_single)) begin
            o_error = `MBMS_ERR_FUNC;
        end else if (is_regs && (i_entry.count == 16'h0000 || i_entry.count > `MBMS_MAX_WORDS)) begin
            o_error = `MBMS_ERR_COUNT;
        end else if (is_bits && (i_entry.count == 16'h0000 || i_entry.count > `MBMS_MAX_BITS)) begin
            o_error = `MBMS_ERR_COUNT;
        end else if ({1'b0, i_entry.db_addr} + {1'b0, o_words} > {1'b0, `MBMS_TABLE_WORDS}) begin
            o_error = `MBMS_ERR_RANGE;
        end
    end
endmodule // mbms_entry_check

//--- logic/mbms_scheduler.sv
`timescale 1ns/1ns
`include "mbms_regs.svh"
module mbms_scheduler #(
    parameter int unsigned P_TIMEOUT_CYCLES = `MBMS_TIMEOUT_MS * (`MBMS_CLK_HZ / 32'd1000)
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Host configuration
    input wire logic i_cfg_write,
    input wire logic [6:0] i_cfg_index,
    input wire mbms_pkg::mbms_entry_t i_cfg_entry,
    input wire logic [6:0] i_cmd_count,
    input wire logic i_run,
    input wire logic [15:0] i_status_base,
    input wire logic [7:0] i_modem_handshake_enable,
    // Host event command
    input wire logic i_event_valid,
    input wire mbms_pkg::mbms_entry_t i_event_entry,
    output logic o_event_taken,
    output logic o_event_done,
    output logic [7:0] o_event_err,
    // Host table and error list access
    input wire logic i_host_wr,
    input wire logic [15:0] i_host_addr,
    input wire logic [15:0] i_host_wdata,
    output logic [15:0] o_host_rdata,
    input wire logic [6:0] i_err_index,
    output logic [7:0] o_err_value,
    // Host transfer image
    output logic o_host_transfer_image_wr,
    output logic [15:0] o_host_transfer_image_addr,
    output logic [15:0] o_host_transfer_image_data,
    // Request to frame builder
    output logic o_req_valid,
    output mbms_pkg::mbms_req_t o_req,
    input wire logic i_req_accept,
    output logic o_tx_valid,
    output logic [15:0] o_tx_word,
    input wire logic i_tx_ready,
    // Reply from frame parser
    input wire logic i_rsp_word_valid,
    input wire logic [15:0] i_rsp_word,
    input wire logic i_rsp_done,
    input wire logic [7:0] i_rsp_code,
    // Modem lines
    input wire logic i_cts,
    output logic o_rts
);
    mbms_pkg::mbms_state_t s_reg;
    mbms_pkg::mbms_state_t s_next;
    mbms_pkg::mbms_entry_t cmd_mem [0:99];
    logic [15:0] table_mem [0:`MBMS_TABLE_WORDS-1];
    mbms_pkg::mbms_entry_t chk_entry;
    logic [7:0] chk_err;
    logic [15:0] chk_words;
    logic [15:0] cur_words [0:99];
    logic [99:0] hit;
    logic [15:0] tbl_addr;
    logic [15:0] tbl_rd;
    logic [15:0] host_rd;
    logic hs_on;
    logic cur_write;
    mbms_pkg::mbms_entry_t cur;
    logic cur_go;

    // One checker serves loads and events; a load in the same cycle holds the event off
    assign chk_entry = i_cfg_write ? i_cfg_entry : i_event_entry;
    mbms_entry_check u_check (
        .i_entry(chk_entry),
        .o_error(chk_err),
        .o_words(chk_words)
    );

    // Host table writes mark overlapping entries as changed
    genvar g;
    generate
        for (g = 0; g < 100; g++) begin : g_dirty
            mbms_entry_check u_span (
                .i_entry(cmd_mem[g]),
                .o_error(),
                .o_words(cur_words[g])
            );
            assign hit[g] = i_host_wr && (i_host_addr >= cmd_mem[g].db_addr)
                && ({1'b0, i_host_addr} < {1'b0, cmd_mem[g].db_addr} + {1'b0, cur_words[g]});
        end
    endgenerate

    // Table reads; out-of-range addresses read as zero
    assign tbl_addr = 16'(s_reg.req.entry.db_addr + s_reg.word_idx);
    assign tbl_rd = (tbl_addr < `MBMS_TABLE_WORDS) ? table_mem[tbl_addr[12:0]] : 16'h0000;
    assign host_rd = (i_host_addr < `MBMS_TABLE_WORDS) ? table_mem[i_host_addr[12:0]] : 16'h0000;
    assign hs_on = (i_modem_handshake_enable == `MBMS_HANDSHAKE_ON);
    assign cur = (s_reg.index < `MBMS_CMD_MAX) ? cmd_mem[s_reg.index] : '0;
    assign cur_write = (s_reg.req.entry.func == `MBMS_FC_WR_COIL) || (s_reg.req.entry.func == `MBMS_FC_WR_REG)
        || (s_reg.req.entry.func == `MBMS_FC_WR_COILS) || (s_reg.req.entry.func == `MBMS_FC_WR_REGS);
    // Entry is eligible: stored error value (load check or last reply status) is none and enable mode allows it
    assign cur_go = (s_reg.errs[s_reg.index] == `MBMS_ERR_NONE)
        && ((cur.enable == `MBMS_EN_CONTINUOUS)
        || (cur.enable == `MBMS_EN_CONDITIONAL && s_reg.dirty[s_reg.index]));

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.event_taken = 1'b0;
        s_next.event_done = 1'b0;
        s_next.wr_en = 1'b0;
        s_next.image_wr = 1'b0;
        s_next.cts_meta = i_cts;
        s_next.cts_sync = s_reg.cts_meta;
        s_next.host_rdata = host_rd;
        s_next.err_rdata = (i_err_index < `MBMS_CMD_MAX) ? s_reg.errs[i_err_index] : 8'h00;
        case (s_reg.phase)
            mbms_pkg::PH_IDLE: begin
                if (i_run) begin
                    s_next.cmd_count = (i_cmd_count > `MBMS_CMD_MAX) ? `MBMS_CMD_MAX : i_cmd_count;
                    s_next.index = 7'h00;
                    s_next.phase = mbms_pkg::PH_SELECT;
                end
            end
            mbms_pkg::PH_SELECT: begin
                if (!i_run) begin
                    s_next.phase = mbms_pkg::PH_IDLE;
                end else if (i_event_valid && !i_cfg_write) begin
                    s_next.event_taken = 1'b1;
                    s_next.is_event = 1'b1;
                    s_next.req = {7'h00, i_event_entry};
                    s_next.words = chk_words;
                    if (chk_err != `MBMS_ERR_NONE) begin
                        s_next.code = chk_err;
                        s_next.phase = mbms_pkg::PH_STATUS;
                    end else begin
                        s_next.phase = mbms_pkg::PH_HANDSHAKE;
                    end
                end else if (s_reg.index >= s_reg.cmd_count) begin
                    s_next.index = 7'h00;
                end else if (cur_go) begin
                    s_next.is_event = 1'b0;
                    s_next.req = {s_reg.index, cur};
                    s_next.words = cur_words[s_reg.index];
                    s_next.phase = mbms_pkg::PH_HANDSHAKE;
                end else begin
                    s_next.index = 7'(s_reg.index + 7'h01);
                end
            end
            mbms_pkg::PH_HANDSHAKE: begin
                // Request-to-send must be seen high a cycle before clear-to-send counts
                if (!hs_on) begin
                    s_next.req_valid = 1'b1;
                    s_next.phase = mbms_pkg::PH_ISSUE;
                end else begin
                    s_next.rts = 1'b1;
                    if (s_reg.rts && s_reg.cts_sync) begin
                        s_next.req_valid = 1'b1;
                        s_next.phase = mbms_pkg::PH_ISSUE;
                    end
                end
            end
            mbms_pkg::PH_ISSUE: begin
                if (i_req_accept) begin
                    s_next.req_valid = 1'b0;
                    s_next.word_idx = 16'h0000;
                    s_next.timer = 32'h0000_0000;
                    if (!s_reg.is_event) begin
                        s_next.dirty[s_reg.req.index] = 1'b0;
                    end
                    s_next.phase = cur_write ? mbms_pkg::PH_SEND : mbms_pkg::PH_WAIT;
                end
            end
            mbms_pkg::PH_SEND: begin
                if (!s_reg.tx_valid) begin
                    s_next.tx_word = tbl_rd;
                    s_next.tx_valid = 1'b1;
                end else if (i_tx_ready) begin
                    s_next.tx_valid = 1'b0;
                    s_next.word_idx = 16'(s_reg.word_idx + 16'h0001);
                    if (16'(s_reg.word_idx + 16'h0001) >= s_reg.words) begin
                        s_next.word_idx = 16'h0000;
                        s_next.phase = mbms_pkg::PH_WAIT;
                    end
                end
            end
            mbms_pkg::PH_WAIT: begin
                s_next.timer = 32'(s_reg.timer + 32'h0000_0001);
                if (i_rsp_word_valid && !cur_write && s_reg.word_idx < s_reg.words) begin
                    s_next.wr_en = 1'b1;
                    s_next.wr_addr = tbl_addr;
                    s_next.wr_data = i_rsp_word;
                    s_next.image_wr = 1'b1;
                    s_next.image_addr = tbl_addr;
                    s_next.image_data = i_rsp_word;
                    s_next.word_idx = 16'(s_reg.word_idx + 16'h0001);
                end
                if (i_rsp_done) begin
                    s_next.code = i_rsp_code;
                    s_next.phase = mbms_pkg::PH_STATUS;
                end else if (s_reg.timer >= 32'(P_TIMEOUT_CYCLES - 1)) begin
                    s_next.code = `MBMS_ERR_TIMEOUT;
                    s_next.phase = mbms_pkg::PH_STATUS;
                end
            end
            mbms_pkg::PH_STATUS: begin
                s_next.rts = 1'b0;
                if (s_reg.is_event) begin
                    s_next.event_done = 1'b1;
                    s_next.event_err = s_reg.code;
                end else begin
                    s_next.errs[s_reg.req.index] = s_reg.code;
                    s_next.wr_en = 1'b1;
                    s_next.wr_addr = 16'(i_status_base + {9'h000, s_reg.req.index});
                    s_next.wr_data = {8'h00, s_reg.code};
                    s_next.index = 7'(s_reg.req.index + 7'h01);
                end
                s_next.phase = mbms_pkg::PH_SELECT;
            end
            default: begin
                s_next.phase = mbms_pkg::PH_IDLE;
            end
        endcase
        // Change marks win over the clear at send time
        s_next.dirty = s_next.dirty | hit;
        if (i_cfg_write && i_cfg_index < `MBMS_CMD_MAX) begin
            s_next.errs[i_cfg_index] = chk_err;
            s_next.dirty[i_cfg_index] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Memories; the block's own table write wins a same-address host write
    always_ff @(posedge i_clk_sys) begin
        if (i_cfg_write && i_cfg_index < `MBMS_CMD_MAX) begin
            cmd_mem[i_cfg_index] <= i_cfg_entry;
        end
        if (s_reg.wr_en && s_reg.wr_addr < `MBMS_TABLE_WORDS) begin
            table_mem[s_reg.wr_addr[12:0]] <= s_reg.wr_data;
        end
        if (i_host_wr && i_host_addr < `MBMS_TABLE_WORDS && !(s_reg.wr_en && s_reg.wr_addr == i_host_addr)) begin
            table_mem[i_host_addr[12:0]] <= i_host_wdata;
        end
    end

    // Outputs straight from state
    assign o_event_taken = s_reg.event_taken;
    assign o_event_done = s_reg.event_done;
    assign o_event_err = s_reg.event_err;
    assign o_host_rdata = s_reg.host_rdata;
    assign o_err_value = s_reg.err_rdata;
    assign o_host_transfer_image_wr = s_reg.image_wr;
    assign o_host_transfer_image_addr = s_reg.image_addr;
    assign o_host_transfer_image_data = s_reg.image_data;
    assign o_req_valid = s_reg.req_valid;
    assign o_req = s_reg.req;
    assign o_tx_valid = s_reg.tx_valid;
    assign o_tx_word = s_reg.tx_word;
    assign o_rts = s_reg.rts;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence req_raised;
        $rose(s_reg.req_valid);
    endsequence

    req_from_issue_a: assert property (req_raised |-> s_reg.phase == mbms_pkg::PH_ISSUE)
        else $error("request raised outside issue phase");
    rts_before_req_a: assert property (req_raised and ##0 hs_on |-> s_reg.rts && $past(s_reg.rts))
        else $error("request without handshake");
    skip_invalid_a: assert property (req_raised and ##0 !s_reg.is_event
        |-> s_reg.errs[s_reg.req.index] == `MBMS_ERR_NONE)
        else $error("invalid entry sent");
    disabled_never_a: assert property (req_raised and ##0 !s_reg.is_event
        |-> s_reg.req.entry.enable != `MBMS_EN_DISABLED)
        else $error("disabled entry sent");
    cond_needs_change_a: assert property (req_raised and ##0 !s_reg.is_event
        and ##0 s_reg.req.entry.enable == `MBMS_EN_CONDITIONAL |-> s_reg.dirty[s_reg.req.index])
        else $error("unchanged conditional entry sent");
    // Bit functions may span up to 16000 bits, which is more table words than a register request
    words_bound_a: assert property (s_reg.req_valid |-> (s_reg.words <= `MBMS_MAX_WORDS)
        || (s_reg.req.entry.count <= `MBMS_MAX_BITS && s_reg.words == 16'((s_reg.req.entry.count + 16'h000f) >> 4)))
        else $error("request exceeds word limit");
    status_write_a: assert property (s_reg.phase == mbms_pkg::PH_STATUS && !s_reg.is_event
        |=> s_reg.wr_en && s_reg.wr_addr == 16'($past(i_status_base) + {9'h000, $past(s_reg.req.index)}))
        else $error("status not written to status block");
    image_mirror_a: assert property (s_reg.phase == mbms_pkg::PH_WAIT && i_rsp_word_valid && !cur_write
        && s_reg.word_idx < s_reg.words |=> s_reg.image_wr && s_reg.wr_en && s_reg.image_data == s_reg.wr_data)
        else $error("read data not mirrored");
    load_error_a: assert property (i_cfg_write && i_cfg_index < `MBMS_CMD_MAX
        |=> s_reg.errs[$past(i_cfg_index)] == $past(chk_err))
        else $error("error value not updated at load");
    wait_bounded_a: assert property (s_reg.phase == mbms_pkg::PH_WAIT
        |-> s_reg.timer < 32'(P_TIMEOUT_CYCLES))
        else $error("reply wait exceeded timeout");
    idle_silent_a: assert property (s_reg.phase == mbms_pkg::PH_IDLE |-> !s_reg.req_valid)
        else $error("request while not configured");
endmodule // mbms_scheduler

//--- verification/mbms_slave_model.sv
`timescale 1ns/1ns
module mbms_slave_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Request and payload from the scheduler
    input wire logic i_req_valid,
    input wire mbms_pkg::mbms_req_t i_req,
    output logic o_req_accept,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    // Reply to the scheduler
    output logic o_rsp_word_valid,
    output logic [15:0] o_rsp_word,
    output logic o_rsp_done,
    output logic [7:0] o_rsp_code,
    // Test controls and modem lines
    input wire logic i_mute,
    input wire logic [3:0] i_delay,
    input wire logic i_rts,
    output logic o_cts
);
    logic busy_reg;
    logic wr_reg;
    logic [15:0] left_reg;
    logic [3:0] wait_reg;
    // One transaction at a time; a muted slave never ends its reply
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {busy_reg, o_req_accept, o_tx_ready, o_rsp_word_valid, o_rsp_done, o_cts} <= '0;
            o_rsp_code <= 8'h00;
            o_rsp_word <= 16'h0000;
        end else begin
            o_req_accept <= 1'b0;
            o_tx_ready <= 1'b0;
            o_rsp_word_valid <= 1'b0;
            o_rsp_done <= 1'b0;
            o_rsp_word <= ~o_rsp_word; // Idle data line never holds a stale word
            o_cts <= i_rts; // Modem grants one cycle late
            if (!busy_reg && i_req_valid && !o_req_accept) begin
                o_req_accept <= 1'b1;
                busy_reg <= 1'b1;
                wait_reg <= i_delay;
                wr_reg <= i_req.entry.func inside {8'h05, 8'h06, 8'h0f, 8'h10};
                left_reg <= (i_req.entry.func inside {8'h01, 8'h02, 8'h0f}) ? (i_req.entry.count + 16'h000f) >> 4 :
                    (i_req.entry.func inside {8'h05, 8'h06}) ? 16'h0001 : i_req.entry.count;
            end else if (busy_reg && wr_reg && left_reg != 16'h0000) begin
                if (i_tx_valid && !o_tx_ready) begin
                    o_tx_ready <= 1'b1;
                    left_reg <= left_reg - 16'h0001;
                end
            end else if (busy_reg && wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end else if (busy_reg && !wr_reg && left_reg != 16'h0000) begin
                o_rsp_word_valid <= 1'b1;
                o_rsp_word <= 16'ha000 + left_reg;
                left_reg <= left_reg - 16'h0001;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                o_rsp_done <= !i_mute;
                o_rsp_code <= 8'h00;
            end
        end
    end
endmodule // mbms_slave_model

//--- verification/mbms_scheduler_bench.sv
`timescale 1ns/1ns
module mbms_scheduler_bench;
    logic i_clk_sys, i_reset, i_cfg_write, i_run, i_event_valid, i_host_wr, i_req_accept, i_tx_ready;
    logic i_rsp_word_valid, i_rsp_done, i_cts, i_mute, o_event_taken, o_event_done, o_rts, rts_seen;
    logic o_host_transfer_image_wr, o_req_valid, o_tx_valid;
    logic [6:0] i_cfg_index, i_cmd_count, i_err_index;
    logic [7:0] i_modem_handshake_enable, o_event_err, o_err_value, i_rsp_code;
    logic [15:0] i_status_base, i_host_addr, i_host_wdata, o_host_rdata, i_rsp_word, o_tx_word, img_a, img_d;
    logic [15:0] o_host_transfer_image_addr, o_host_transfer_image_data;
    logic [3:0] i_delay;
    mbms_pkg::mbms_entry_t i_cfg_entry, i_event_entry;
    mbms_pkg::mbms_req_t o_req;
    mbms_pkg::mbms_entry_t row_e [10];
    logic [7:0] row_x [10];
    logic [6:0] seq [$];
    logic [15:0] txq [$];
    int failures = 0, checks = 0, cycles = 0;
    // Short timeout keeps the muted-slave case brief
    mbms_scheduler #(.P_TIMEOUT_CYCLES(64)) dut (.i_clk_sys, .i_reset, .i_cfg_write, .i_cfg_index, .i_cfg_entry,
        .i_cmd_count, .i_run, .i_status_base, .i_modem_handshake_enable, .i_event_valid, .i_event_entry,
        .o_event_taken, .o_event_done, .o_event_err, .i_host_wr, .i_host_addr, .i_host_wdata, .o_host_rdata,
        .i_err_index, .o_err_value, .o_host_transfer_image_wr, .o_host_transfer_image_addr,
        .o_host_transfer_image_data, .o_req_valid, .o_req, .i_req_accept, .o_tx_valid, .o_tx_word,
        .i_tx_ready, .i_rsp_word_valid, .i_rsp_word, .i_rsp_done, .i_rsp_code, .i_cts, .o_rts);
    mbms_slave_model slave (.i_clk_sys, .i_reset, .i_req_valid(o_req_valid), .i_req(o_req),
        .o_req_accept(i_req_accept), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
        .o_rsp_word_valid(i_rsp_word_valid), .o_rsp_word(i_rsp_word), .o_rsp_done(i_rsp_done),
        .o_rsp_code(i_rsp_code), .i_mute, .i_delay, .i_rts(o_rts), .o_cts(i_cts));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic load(input logic [6:0] k, input mbms_pkg::mbms_entry_t e);
        @(posedge i_clk_sys);
        i_cfg_write <= 1'b1;
        i_cfg_index <= k;
        i_cfg_entry <= e;
        @(posedge i_clk_sys);
        i_cfg_write <= 1'b0;
    endtask
    task automatic host_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_host_wr <= 1'b1;
        i_host_addr <= a;
        i_host_wdata <= d;
        @(posedge i_clk_sys);
        i_host_wr <= 1'b0;
    endtask
    // Reads land one cycle after the address; sample well clear of the edge
    task automatic rd_check(input string name, input logic [15:0] a, input logic [15:0] exp);
        @(posedge i_clk_sys);
        i_host_addr <= a;
        tick(2);
        #1 check(name, exp, o_host_rdata);
    endtask
    task automatic err_check(input string name, input logic [6:0] k, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_err_index <= k;
        tick(2);
        #1 check(name, {8'h00, exp}, {8'h00, o_err_value});
    endtask
    // Observe handshakes as sampled by the design
    always @(posedge i_clk_sys) begin
        cycles++;
        if (o_req_valid === 1'b1 && i_req_accept === 1'b1) seq.push_back(o_req.index);
        if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) txq.push_back(o_tx_word);
        if (o_host_transfer_image_wr === 1'b1) {img_a, img_d} = {o_host_transfer_image_addr, o_host_transfer_image_data};
        if (o_rts === 1'b1) rts_seen = 1'b1;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        {i_cfg_write, i_run, i_event_valid, i_host_wr, i_mute, rts_seen} = '0;
        {i_cfg_index, i_err_index, i_cfg_entry, i_event_entry, i_host_addr, i_host_wdata} = '0;
        {i_cmd_count, i_status_base, i_modem_handshake_enable, i_delay} = {7'h04, 16'h0100, 8'h00, 4'h0};
        // No two served commands write the same table words
        row_e = '{{2'h1, 8'h01, 8'h03, 16'h000a, 16'h0002}, {2'h0, 8'h01, 8'h03, 16'h0000, 16'h0001},
            {2'h1, 8'h01, 8'h07, 16'h0000, 16'h0001}, {2'h1, 8'h02, 8'h10, 16'h0014, 16'h0001},
            {2'h3, 8'h01, 8'h03, 16'h0000, 16'h0001}, {2'h1, 8'h01, 8'h03, 16'h0000, 16'h0000},
            {2'h1, 8'h01, 8'h04, 16'h0000, 16'h007e}, {2'h1, 8'h01, 8'h01, 16'h0000, 16'h3e81},
            {2'h1, 8'h01, 8'h02, 16'h1387, 16'h0011}, {2'h1, 8'h01, 8'h0f, 16'h0000, 16'h3e80}};
        row_x = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h03, 8'h03, 8'h03, 8'h04, 8'h00};
        i_reset = 1'b1;
        tick(12);
        i_reset <= 1'b0;
        tick(1);
        #1 check("req valid after reset", 16'h0000, {15'h0000, o_req_valid});
        for (int k = 0; k < 10; k++) begin
            load(k[6:0], row_e[k]);
            err_check("entry check", k[6:0], row_x[k]);
        end
        $display("test entry_check done");
        host_write(16'h0014, 16'h1234);
        i_run <= 1'b1;
        for (int n = 0; n < 3000 && seq.size() < 3; n++) tick(1);
        i_run <= 1'b0;
        tick(100);
        check("request count", 16'h0003, seq.size());
        check("first index", 16'h0000, {9'h000, seq[0]});
        check("second index", 16'h0003, {9'h000, seq[1]});
        check("third index", 16'h0000, {9'h000, seq[2]});
        check("write payload", 16'h1234, txq[0]);
        check("image addr", 16'h000b, img_a);
        check("image data", 16'ha001, img_d);
        rd_check("table word", 16'h000a, 16'ha002);
        rd_check("status read", 16'h0100, 16'h0000);
        rd_check("status write", 16'h0103, 16'h0000);
        err_check("write error", 7'h03, 8'h00);
        $display("test list_run done");
        @(posedge i_clk_sys);
        {i_cmd_count, i_mute, i_delay, i_run} <= {7'h01, 1'b1, 4'h9, 1'b1};
        seq.delete();
        for (int n = 0; n < 1000 && seq.size() < 1; n++) tick(1);
        i_run <= 1'b0;
        tick(150);
        err_check("timeout error", 7'h00, 8'hff);
        rd_check("timeout status", 16'h0100, 16'h00ff);
        $display("test timeout done");
        @(posedge i_clk_sys);
        {i_mute, i_modem_handshake_enable} <= {1'b0, 8'h01};
        load(7'h00, {2'h2, 8'h01, 8'h10, 16'h0014, 16'h0001});
        seq.delete();
        txq.delete();
        i_run <= 1'b1;
        tick(300);
        check("send while unchanged", 16'h0001, seq.size());
        check("rts raised", 16'h0001, {15'h0000, rts_seen});
        host_write(16'h0014, 16'h5678);
        for (int n = 0; n < 1000 && seq.size() < 2; n++) tick(1);
        tick(30);
        check("resend after change", 16'h0002, seq.size());
        check("new payload", 16'h5678, txq[1]);
        $display("test conditional done");
        @(posedge i_clk_sys);
        i_event_entry <= {2'h1, 8'h01, 8'h07, 16'h0000, 16'h0001};
        i_event_valid <= 1'b1;
        for (int n = 0; n < 500 && o_event_taken !== 1'b1; n++) tick(1);
        i_event_valid <= 1'b0;
        for (int n = 0; n < 50 && o_event_done !== 1'b1; n++) tick(1);
        check("event error", 16'h0002, {8'h00, o_event_err});
        // A valid read event goes out on the link and lands in the table
        @(posedge i_clk_sys);
        i_event_entry <= {2'h1, 8'h01, 8'h03, 16'h0030, 16'h0001};
        i_event_valid <= 1'b1;
        for (int n = 0; n < 500 && o_event_taken !== 1'b1; n++) tick(1);
        i_event_valid <= 1'b0;
        for (int n = 0; n < 200 && o_event_done !== 1'b1; n++) tick(1);
        check("event ok", 16'h0000, {8'h00, o_event_err});
        check("event image addr", 16'h0030, img_a);
        i_run <= 1'b0;
        tick(50);
        $display("test event done");
        print_verdict();
    end
endmodule // mbms_scheduler_bench
